/* rtl/rsse_pkg.sv */
// Purpose: Shared constants and types for the rotate/halt/subtract unit
// Assumes: 14-bit instruction words, 8-bit data, four phases per cycle
// Notes:   Register map covers the APB slave of the unit
package rsse_pkg;
	localparam logic [5:0]  OPC_ROTL       = 6'h0D;
	localparam logic [5:0]  OPC_ROTR       = 6'h0C;
	localparam logic [4:0]  OPC_LITSUB     = 5'h1E;
	localparam logic [13:0] OPC_HALT       = 14'h0063;
	localparam logic [7:0]  WDOG_CLEAR     = 8'h00;
	localparam logic [7:0]  PRESC_CLEAR    = 8'h00;
	localparam logic [11:0] ADDR_INSTR     = 12'h000;
	localparam logic [11:0] ADDR_ACC       = 12'h004;
	localparam logic [11:0] ADDR_FREG      = 12'h008;
	localparam logic [11:0] ADDR_STATUS    = 12'h00C;
	localparam logic [11:0] ADDR_WDOG      = 12'h010;
	localparam int          ST_CARRY       = 0;
	localparam int          ST_HALF        = 1;
	localparam int          ST_ZERO        = 2;
	localparam int          ST_PDOWN       = 3;
	localparam int          ST_TOUT        = 4;
	localparam int          ST_HALTED      = 5;
	localparam int          ST_BUSY        = 6;
	localparam logic [7:0]  RST_ACC        = 8'h00;
	localparam logic [7:0]  RST_FREG       = 8'h00;
	localparam logic [4:0]  RST_FLAGS      = 5'h18;

	typedef enum logic [1:0] {
		RSSE_Q1,
		RSSE_Q2,
		RSSE_Q3,
		RSSE_Q4
	} rsse_phase_t;

	typedef struct packed {
		logic       timeout_status;
		logic       powerdown_flag;
		logic       zero;
		logic       half_byte_flag;
		logic       carry;
	} rsse_flags_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} rsse_apb_rsp_t;
endpackage

/* rtl/rsse_exec.sv */
// Purpose: Executes rotate-left, rotate-right, halt and literal subtract
// Assumes: Software loads word and operands over APB, then the unit runs
// Notes:   One instruction cycle is four clocks, Q1 to Q4
//
// Notes on behaviour
// RL1 - Rotate left moves old carry into bit 0, bit 7 into carry, d picks target.
// RL2 - Rotate right moves old carry into bit 7, bit 0 into carry, d picks target.
// RL3 - The fixed halt word is decoded as a one-word one-cycle no-operand op.
// RL4 - Halt clears the power-down flag and sets the time-out flag.
// RL5 - Halt zeroes the watchdog counter and its prescaler.
// RL6 - Halt puts the core in low power with the oscillator stopped.
// RL7 - Halt decodes in Q1, idles in Q2 and Q3 and halts in Q4.
// RL8 - Literal subtract writes literal minus accumulator to the accumulator.
// RL9 - Subtract updates carry, half-byte and zero; rotates change only carry.
// RL10 - After subtract carry is an inverted borrow, set when no borrow.
// RL11 - Rotate and subtract read in Q2, compute in Q3 and write in Q4.
`timescale 1ns/1ps
`default_nettype none
module rsse_exec
	import rsse_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// APB slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// Watchdog and power
	input  wire logic        wake_in,
	output logic      [7:0]  watchdog_counter_out,
	output logic      [7:0]  prescaler_out,
	output logic             osc_stop_out
);
	////////////////////////////////////////////////////////////////////////
	// State
	rsse_phase_t ph_q, ph_d;
	logic        busy_q, busy_d;
	logic        halt_q, halt_d;
	logic [13:0] instr_q, instr_d;
	logic [7:0]  acc_q, acc_d;
	logic [7:0]  freg_q, freg_d;
	logic [7:0]  opnd_q, opnd_d;
	logic [7:0]  res_q, res_d;
	logic        cres_q, cres_d;
	logic        hres_q, hres_d;
	logic [7:0]  wdog_q, wdog_d;
	logic [7:0]  presc_q, presc_d;
	logic        wk1_q, wk2_q;
	rsse_flags_t fl_q, fl_d;
	logic        is_rotl, is_rotr, is_sub, is_halt, dest_f;
	logic [8:0]  diff;
	logic [4:0]  ndiff;
	logic        wr_acc, rd_acc;

	assign is_rotl = instr_q[13:8] == OPC_ROTL;
	assign is_rotr = instr_q[13:8] == OPC_ROTR;
	assign is_sub  = instr_q[13:9] == OPC_LITSUB;
	assign is_halt = instr_q == OPC_HALT; // [RL3]
	assign dest_f  = instr_q[7];
	assign diff    = {1'b0, instr_q[7:0]} + {1'b0, ~opnd_q} + 9'h001;
	assign ndiff   = {1'b0, instr_q[3:0]} + {1'b0, ~opnd_q[3:0]} + 5'h01;
	assign wr_acc  = psel_in && penable_in && pwrite_in;
	assign rd_acc  = psel_in && !pwrite_in;

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		ph_d    = ph_q;
		busy_d  = busy_q;
		halt_d  = halt_q;
		instr_d = instr_q;
		acc_d   = acc_q;
		freg_d  = freg_q;
		opnd_d  = opnd_q;
		res_d   = res_q;
		cres_d  = cres_q;
		hres_d  = hres_q;
		wdog_d  = halt_q ? wdog_q : wdog_q + 8'h01;
		presc_d = halt_q ? presc_q : presc_q + 8'h01;
		fl_d    = fl_q;
		if (halt_q && wk2_q) begin
			halt_d = 1'b0;
		end
		if (busy_q) begin
			ph_d = rsse_phase_t'(ph_q + 2'h1);
			unique case (ph_q)
				RSSE_Q1: begin
				end
				RSSE_Q2: begin
					opnd_d = is_sub ? acc_q : freg_q; // [RL11]
				end
				RSSE_Q3: begin
					if (is_rotl) begin
						res_d  = {opnd_q[6:0], fl_q.carry}; // [RL1]
						cres_d = opnd_q[7]; // [RL1]
					end else if (is_rotr) begin
						res_d  = {fl_q.carry, opnd_q[7:1]}; // [RL2]
						cres_d = opnd_q[0]; // [RL2]
					end else if (is_sub) begin
						res_d  = diff[7:0]; // [RL8]
						cres_d = diff[8]; // [RL10]
						hres_d = ndiff[4];
					end
				end
				RSSE_Q4: begin
					busy_d = 1'b0;
					if (is_rotl || is_rotr) begin
						fl_d.carry = cres_q; // [RL9]
						if (dest_f) begin
							freg_d = res_q;
						end else begin
							acc_d = res_q;
						end
					end else if (is_sub) begin
						acc_d             = res_q; // [RL8]
						fl_d.carry        = cres_q; // [RL9]
						fl_d.half_byte_flag = hres_q; // [RL9]
						fl_d.zero         = res_q == 8'h00; // [RL9]
					end else if (is_halt) begin
						fl_d.powerdown_flag = 1'b0; // [RL4]
						fl_d.timeout_status = 1'b1; // [RL4]
						wdog_d  = WDOG_CLEAR; // [RL5]
						presc_d = PRESC_CLEAR; // [RL5]
						halt_d  = 1'b1; // [RL7]
					end
				end
			endcase
		end else if (wr_acc && !halt_q) begin
			unique case (paddr_in)
				ADDR_INSTR: begin
					instr_d = pwdata_in[13:0];
					busy_d  = 1'b1;
					ph_d    = RSSE_Q1;
				end
				ADDR_ACC:    acc_d  = pwdata_in[7:0];
				ADDR_FREG:   freg_d = pwdata_in[7:0];
				ADDR_STATUS: fl_d   = rsse_flags_t'(pwdata_in[4:0]);
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ph_q    <= RSSE_Q1;
			busy_q  <= 1'b0;
			halt_q  <= 1'b0;
			instr_q <= 14'h0000;
			acc_q   <= RST_ACC;
			freg_q  <= RST_FREG;
			opnd_q  <= 8'h00;
			res_q   <= 8'h00;
			cres_q  <= 1'b0;
			hres_q  <= 1'b0;
			wdog_q  <= WDOG_CLEAR;
			presc_q <= PRESC_CLEAR;
			fl_q    <= rsse_flags_t'(RST_FLAGS);
			wk1_q   <= 1'b0;
			wk2_q   <= 1'b0;
		end else begin
			ph_q    <= ph_d;
			busy_q  <= busy_d;
			halt_q  <= halt_d;
			instr_q <= instr_d;
			acc_q   <= acc_d;
			freg_q  <= freg_d;
			opnd_q  <= opnd_d;
			res_q   <= res_d;
			cres_q  <= cres_d;
			hres_q  <= hres_d;
			wdog_q  <= wdog_d;
			presc_q <= presc_d;
			fl_q    <= fl_d;
			wk1_q   <= wake_in;
			wk2_q   <= wk1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	always_comb begin
		prdata_out = 32'h0000_0000;
		unique case (paddr_in)
			ADDR_INSTR:  prdata_out = {18'h00000, instr_q};
			ADDR_ACC:    prdata_out = {24'h000000, acc_q};
			ADDR_FREG:   prdata_out = {24'h000000, freg_q};
			ADDR_STATUS: prdata_out = {25'h0000000, busy_q, halt_q, fl_q};
			ADDR_WDOG:   prdata_out = {16'h0000, presc_q, wdog_q};
			default:     prdata_out = 32'h0000_0000;
		endcase
		if (!rd_acc) begin
			prdata_out = 32'h0000_0000;
		end
	end
	assign pready_out  = !(busy_q && pwrite_in);
	assign pslverr_out = psel_in && penable_in &&
		!(paddr_in inside {ADDR_INSTR, ADDR_ACC, ADDR_FREG, ADDR_STATUS,
		ADDR_WDOG});
	assign watchdog_counter_out = wdog_q;
	assign prescaler_out        = presc_q;
	assign osc_stop_out         = halt_q; // [RL6]

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_exec_start;
		busy_q && ph_q == RSSE_Q1;
	endsequence
	property p_rotl;
		@(posedge clk_in) disable iff (rst_in)
		s_exec_start and (is_rotl && !dest_f) |->
		##4 acc_q == {$past(freg_q[6:0], 4), $past(fl_q.carry, 4)};
	endproperty
	a_rotl: assert property (p_rotl) else $error("rotl result wrong"); // [RL1]
	property p_rotr;
		@(posedge clk_in) disable iff (rst_in)
		s_exec_start and is_rotr |->
		##4 fl_q.carry == $past(freg_q[0], 4);
	endproperty
	a_rotr: assert property (p_rotr) else $error("rotr carry wrong"); // [RL2]
	property p_halt_one;
		@(posedge clk_in) disable iff (rst_in)
		s_exec_start and is_halt |-> !halt_q [*4] ##1 halt_q;
	endproperty
	a_halt_one: assert property (p_halt_one) else $error("halt timing"); // [RL7]
	property p_halt_flags;
		@(posedge clk_in) disable iff (rst_in)
		$rose(halt_q) |-> !fl_q.powerdown_flag && fl_q.timeout_status;
	endproperty
	a_halt_flags: assert property (p_halt_flags) else $error("flags"); // [RL4]
	property p_halt_wdog;
		@(posedge clk_in) disable iff (rst_in)
		$rose(halt_q) |-> wdog_q == 8'h00 && presc_q == 8'h00;
	endproperty
	a_halt_wdog: assert property (p_halt_wdog) else $error("wdog"); // [RL5]
	property p_osc;
		@(posedge clk_in) disable iff (rst_in)
		$rose(osc_stop_out) |-> $past(busy_q && ph_q == RSSE_Q4 && is_halt);
	endproperty
	a_osc: assert property (p_osc) else $error("osc stop"); // [RL6]
	property p_sub;
		@(posedge clk_in) disable iff (rst_in)
		s_exec_start and is_sub |->
		##4 acc_q == 8'($past(instr_q[7:0], 4) - $past(acc_q, 4));
	endproperty
	a_sub: assert property (p_sub) else $error("sub result"); // [RL8]
	property p_sub_c;
		@(posedge clk_in) disable iff (rst_in)
		s_exec_start and is_sub |->
		##4 fl_q.carry == ($past(instr_q[7:0], 4) >= $past(acc_q, 4))
		&& fl_q.zero == (acc_q == 8'h00)
		&& fl_q.half_byte_flag ==
		($past(instr_q[3:0], 4) >= $past(acc_q[3:0], 4));
	endproperty
	a_sub_c: assert property (p_sub_c) else $error("sub flags"); // [RL10]
	property p_rot_flags;
		@(posedge clk_in) disable iff (rst_in)
		s_exec_start and (is_rotl || is_rotr) |->
		##4 fl_q.zero == $past(fl_q.zero, 4);
	endproperty
	a_rot_flags: assert property (p_rot_flags) else $error("zf"); // [RL9]
	property p_phase;
		@(posedge clk_in) disable iff (rst_in)
		s_exec_start and is_sub |-> ##2 opnd_q == $past(acc_q, 2);
	endproperty
	a_phase: assert property (p_phase) else $error("read phase"); // [RL11]
	property p_decode;
		@(posedge clk_in) disable iff (rst_in)
		s_exec_start and (instr_q == OPC_HALT) |-> busy_q [*4] ##1 !busy_q;
	endproperty
	a_decode: assert property (p_decode) else $error("decode"); // [RL3]
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Purpose: Self-checking bench for the rotate/halt/subtract unit
// Assumes: APB access to the unit, zero-wait answers when idle
// Notes:   Each scenario is a task that judges its own results
`timescale 1ns/1ps
`default_nettype none
module testbench
	import rsse_pkg::*;
;
	logic        clk_in;
	logic        rst_in;
	logic        psel_in;
	logic        penable_in;
	logic        pwrite_in;
	logic [11:0] paddr_in;
	logic [31:0] pwdata_in;
	logic [31:0] prdata_out;
	logic        pready_out;
	logic        pslverr_out;
	logic        wake_in;
	logic [7:0]  watchdog_counter_out;
	logic [7:0]  prescaler_out;
	logic        osc_stop_out;
	logic        slverr_q;
	logic [31:0] rd;
	int          n_errors;
	int          comparisons;

	always #5 clk_in = ~clk_in;

	rsse_exec u_dut (
		.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in),
		.prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .wake_in(wake_in),
		.watchdog_counter_out(watchdog_counter_out),
		.prescaler_out(prescaler_out), .osc_stop_out(osc_stop_out)
	);

	////////////////////////////////////////////////////////////////////////
	task final_report;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	// One APB transfer, entered just after a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_in);
			if (pready_out === 1'b1)
				break;
		end
		if (i == 20) begin
			n_errors++;
			$display("unexpected at %0t: no pready", $time);
			final_report;
		end
		rd = prdata_out;
		slverr_q = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge clk_in);
	endtask

	// Load operands, start one instruction, poll until it is done
	task run(input logic [7:0] acc, input logic [7:0] fr, input logic [4:0] st,
		input logic [13:0] ins);
		int i;
		apb(1'b1, ADDR_ACC, {24'h0, acc});
		apb(1'b1, ADDR_FREG, {24'h0, fr});
		apb(1'b1, ADDR_STATUS, {27'h0, st});
		apb(1'b1, ADDR_INSTR, {18'h0, ins});
		for (i = 0; i < 10; i++) begin
			apb(1'b0, ADDR_STATUS, 32'h0);
			if (rd[ST_BUSY] === 1'b0)
				break;
		end
		if (i == 10) begin
			n_errors++;
			$display("unexpected at %0t: instruction never done", $time);
			final_report;
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	task t_reset;
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd[4:0], 32'h18, "status reset");
		apb(1'b0, ADDR_ACC, 32'h0);
		chk(rd, 32'h0, "acc reset");
		apb(1'b0, 12'h020, 32'h0);
		chk(slverr_q, 32'h1, "unmapped error");
	endtask

	task t_rot(input logic left, input logic d, input logic [7:0] f, input logic c);
		logic [7:0] res;
		logic       nc;
		res = left ? {f[6:0], c} : {c, f[7:1]};
		nc = left ? f[7] : f[0];
		run(8'h3C, f, {4'hF, c}, {left ? OPC_ROTL : OPC_ROTR, d, 7'h05});
		apb(1'b0, ADDR_ACC, 32'h0);
		chk(rd, d ? 32'h3C : {24'h0, res}, "rotate acc");
		apb(1'b0, ADDR_FREG, 32'h0);
		chk(rd, {24'h0, d ? res : f}, "rotate reg");
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd[4:0], {4'hF, nc}, "rotate flags");
	endtask

	task t_sub(input logic [7:0] k, input logic [7:0] w, input logic x);
		logic [7:0] res;
		res = k - w;
		run(w, 8'h00, 5'h18, {OPC_LITSUB, x, k});
		apb(1'b0, ADDR_ACC, 32'h0);
		chk(rd, {24'h0, res}, "subtract acc");
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd[4:0], {2'b11, res == 8'h00, k[3:0] >= w[3:0], k >= w},
			"subtract flags");
	endtask

	task t_halt;
		int i;
		run(8'h11, 8'h22, 5'h08, OPC_HALT);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd[5:0], 32'h30, "halt status");
		chk(osc_stop_out, 32'h1, "oscillator stop");
		chk(watchdog_counter_out, 32'h0, "watchdog clear");
		chk(prescaler_out, 32'h0, "prescaler clear");
		apb(1'b0, ADDR_WDOG, 32'h0);
		chk(rd, 32'h0, "watchdog read");
		apb(1'b1, ADDR_ACC, 32'h55);
		apb(1'b0, ADDR_ACC, 32'h0);
		chk(rd, 32'h11, "write while halted");
		wake_in <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_in);
			if (osc_stop_out === 1'b0)
				break;
		end
		if (i == 20) begin
			n_errors++;
			$display("unexpected at %0t: no wake", $time);
			final_report;
		end
		wake_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		chk(watchdog_counter_out != 8'h00, 32'h1, "watchdog runs");
		chk(prescaler_out != 8'h00, 32'h1, "prescaler runs");
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk_in = 1'b0;
		rst_in = 1'b1;
		psel_in = 1'b0;
		penable_in = 1'b0;
		pwrite_in = 1'b0;
		paddr_in = 12'h000;
		pwdata_in = 32'h0;
		wake_in = 1'b0;
		n_errors = 0;
		comparisons = 0;
		repeat (12) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		t_reset;
		for (int k = 0; k < 4; k++)
			t_rot(k[0], k[1], k[1] ? 8'h65 : 8'hA6, ~k[0]);
		t_sub(8'h02, 8'h01, 1'b0);
		t_sub(8'h02, 8'h02, 1'b0);
		t_sub(8'h02, 8'h03, 1'b1);
		t_sub(8'h10, 8'h01, 1'b1);
		t_halt;
		final_report;
	end
endmodule
`default_nettype wire
